// ==== hdl/clk_div.sv ====
// tick divider: enable pulse and clock level, ratio taken only at a period boundary
`timescale 1ns/100ps
`default_nettype none
module clk_div (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       tick_in,
    input  wire logic [3:0] ratio_in,
    output logic            en_out,
    output logic            level_out
);
    logic [3:0] cnt_r;
    logic [3:0] ratio_r;
    wire        last    = (cnt_r == ratio_r - 4'h1);
    wire  [3:0] cnt_nxt = last ? 4'h0 : cnt_r + 4'h1;
    // widened so a ratio of 15 does not wrap to a zero high time
    wire  [3:0] half    = 4'((5'(ratio_r) + 5'h01) >> 1);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_r     <= 4'h0;
            ratio_r   <= 4'h1;
            en_out    <= 1'b0;
            level_out <= 1'b0;
        end else begin
            en_out <= tick_in & last;
            if (tick_in) begin
                cnt_r <= cnt_nxt;
                // new ratio only at wrap so no runt period appears
                if (last) begin
                    ratio_r <= ratio_in;
                end
                if (ratio_r == 4'h1) begin
                    level_out <= ~level_out;
                end else begin
                    level_out <= (cnt_nxt < half);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== hdl/pin_sync.sv ====
// three-stage synchroniser for pin inputs, change accepted when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int          WIDTH     = 1,
    parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    wire  [WIDTH-1:0] agree = ~(s2_r ^ s3_r);
    wire  [WIDTH-1:0] rst_v = RESET_VAL[WIDTH-1:0];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s1_r      <= rst_v;
            s2_r      <= rst_v;
            s3_r      <= rst_v;
            level_out <= rst_v;
        end else begin
            s1_r      <= pin_in;
            s2_r      <= s1_r;
            s3_r      <= s2_r;
            level_out <= (agree & s3_r) | (~agree & level_out);
        end
    end
endmodule
`default_nettype wire

// ==== hdl/pmc_defines.svh ====
// register offsets, field positions, reset values and counts for the power/clock controller
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

`define PMC_ADDR_W          5
`define PMC_OFF_PLL_CONTROL_REGISTER     5'h00
`define PMC_OFF_DIVIDER     5'h04
`define PMC_OFF_REGULATOR   5'h08
`define PMC_OFF_MODE        5'h0C
`define PMC_OFF_SYNC_MEM    5'h10
`define PMC_OFF_ASYNC_MEM   5'h14

`define PMC_PLL_BYPASS_BIT  0
`define PMC_PLL_MULT_LSB    1
`define PMC_PLL_MULT_MSB    6
`define PMC_PLL_OFF_BIT     7
`define PMC_PLL_MULT_RST    6'h0A
`define PMC_PLL_MULT_MAX    6'h3F

`define PMC_SSEL_LSB        0
`define PMC_SSEL_MSB        3
`define PMC_CSEL_LSB        4
`define PMC_CSEL_MSB        5
`define PMC_SSEL_RST        4'h5
`define PMC_SSEL_MIN        4'h2
`define PMC_CSEL_RST        2'h0

`define PMC_REGULATOR_FREQUENCY_FIELD_LSB        0
`define PMC_REGULATOR_FREQUENCY_FIELD_MSB        1
`define PMC_REGULATOR_FREQUENCY_FIELD_RST        2'h3
`define PMC_REGULATOR_FREQUENCY_FIELD_OFF        2'h0
`define PMC_VR_SPARE_LSB    2
`define PMC_VR_SPARE_MSB    7
`define PMC_VR_SPARE_RST    6'h00

`define PMC_CMD_SLEEP       2'h1
`define PMC_CMD_DEEP_SLEEP  2'h2
`define PMC_CLOCK_OUTPUT_PIN_EN_BIT   0

`define PMC_SYNC_STAGES     3
`define PMC_WAKE_W          5

`endif

// ==== hdl/pmc_pkg.sv ====
// types shared by the power-mode and clock control design
package pmc_pkg;

    typedef enum logic [2:0] {
        MODE_FULL_ON    = 3'b000,
        MODE_ACTIVE     = 3'b001,
        MODE_SLEEP      = 3'b010,
        MODE_DEEP_SLEEP = 3'b011,
        MODE_HIBERNATE  = 3'b100
    } power_mode_t;

endpackage

// ==== hdl/power_mode_clock_control.sv ====
// power-mode sequencing, clock division and register slave of the clock/power controller
//
// Contract
// - deep sleep gates core and system clocks
// - deep sleep blocks asynchronous resource access
// - deep sleep exits only on reset/RTC
// - RTC interrupt in deep sleep gives active
// - reset in deep sleep gives full-on
// - frequency field 00 enters hibernate, supply off
// - hibernate tri-states the external pins
// - listed wake sources end hibernate
// - RTC or reset wake starts reset sequence
// - hibernate keeps only regulator and RTC registers
// - PLL multiplier programmable from 1 to 63
// - divider write changes clocks on the fly
// - clock pin off until memory controls enable
// - peripherals run from the system clock
// - system select is ratio 2..15, default 5
// - system select change needs no relock
// - core select 1/2/4/8, default 1
// - sleep wake checks bypass for target mode
// - active mode runs clocks at input rate
`timescale 1ns/100ps
`default_nettype none
`include "pmc_defines.svh"
module power_mode_clock_control
    import pmc_pkg::*;
(
    input  wire logic                   clk_sys_in,
    input  wire logic                   sys_rst_in,
    input  wire logic [`PMC_ADDR_W-1:0] avs_address_in,
    input  wire logic                   avs_read_in,
    input  wire logic                   avs_write_in,
    input  wire logic [31:0]            avs_writedata_in,
    output logic      [31:0]            avs_readdata_out,
    output logic                        avs_waitrequest_out,
    input  wire logic                   input_clock_in,
    input  wire logic                   reset_pin_n_in,
    input  wire logic                   rtc_irq_in,
    input  wire logic                   rtc_wakeup_in,
    input  wire logic                   sleep_wake_in,
    input  wire logic [`PMC_WAKE_W-1:0] hib_wake_in,
    output logic                        core_clk_en_out,
    output logic                        sys_clk_en_out,
    output logic                        clock_output_pin_out,
    output logic                        clock_output_oe_out,
    output logic                        pins_hiz_out,
    output logic                        vddint_on_out,
    output logic                        async_block_out,
    output logic                        hw_reset_out,
    output logic [5:0]                  pll_mult_out
);
    localparam int SYNC_W = `PMC_WAKE_W + 5;

    // pin synchronisation
    logic [SYNC_W-1:0] pins_s;
    pin_sync #(
        .WIDTH     (SYNC_W),
        .RESET_VAL (32'h0000_0002)
    ) u_pin_sync (
        .clk_in    (clk_sys_in),
        .rst_in    (sys_rst_in),
        .pin_in    ({hib_wake_in, sleep_wake_in, rtc_wakeup_in, rtc_irq_in, reset_pin_n_in, input_clock_in}),
        .level_out (pins_s)
    );
    wire                   in_clk_s   = pins_s[0];
    wire                   rst_pin_s  = pins_s[1];
    wire                   rtc_irq_s  = pins_s[2];
    wire                   rtc_wake_s = pins_s[3];
    wire                   slp_wake_s = pins_s[4];
    wire [`PMC_WAKE_W-1:0] hib_src_s  = pins_s[SYNC_W-1:5];
    logic in_clk_prev_r;
    logic rst_pin_prev_r;
    wire  in_tick     = in_clk_s & ~in_clk_prev_r;
    wire  rst_pin_evt = rst_pin_prev_r & ~rst_pin_s;
    // state and registers
    power_mode_t mode_r;
    power_mode_t mode_nxt;
    logic        bypass_r;
    logic        pll_off_r;
    logic [5:0]  mult_r;
    logic [3:0]  ssel_r;
    logic [1:0]  csel_r;
    logic [1:0]  regulator_frequency_field_r;
    logic [5:0]  vr_spare_r;
    logic        sync_clock_output_pin_r;
    logic        async_clock_output_pin_r;
    logic        wait_r;

    // bus decode
    wire running   = (mode_r == MODE_FULL_ON) | (mode_r == MODE_ACTIVE);
    wire wr_acc    = avs_write_in & ~wait_r & running;
    wire hit_pll   = (avs_address_in == `PMC_OFF_PLL_CONTROL_REGISTER);
    wire hit_div   = (avs_address_in == `PMC_OFF_DIVIDER);
    wire hit_vr    = (avs_address_in == `PMC_OFF_REGULATOR);
    wire hit_mode  = (avs_address_in == `PMC_OFF_MODE);
    wire hit_smem  = (avs_address_in == `PMC_OFF_SYNC_MEM);
    wire hit_amem  = (avs_address_in == `PMC_OFF_ASYNC_MEM);
    wire [5:0] wd_mult  = avs_writedata_in[`PMC_PLL_MULT_MSB:`PMC_PLL_MULT_LSB];
    wire [3:0] wd_ssel  = avs_writedata_in[`PMC_SSEL_MSB:`PMC_SSEL_LSB];
    wire [1:0] wd_regulator_frequency_field  = avs_writedata_in[`PMC_REGULATOR_FREQUENCY_FIELD_MSB:`PMC_REGULATOR_FREQUENCY_FIELD_LSB];
    wire [1:0] wd_cmd   = avs_writedata_in[1:0];
    wire       wd_byp   = avs_writedata_in[`PMC_PLL_BYPASS_BIT];
    wire       wd_off   = avs_writedata_in[`PMC_PLL_OFF_BIT];
    wire       hib_req  = wr_acc & hit_vr & (wd_regulator_frequency_field == `PMC_REGULATOR_FREQUENCY_FIELD_OFF);
    // sleep needs a live PLL, so it is refused while the PLL is off
    wire       slp_req  = wr_acc & hit_mode & (wd_cmd == `PMC_CMD_SLEEP) & ~pll_off_r;
    wire       deep_req = wr_acc & hit_mode & (wd_cmd == `PMC_CMD_DEEP_SLEEP);

    // wake decode
    wire in_deep   = (mode_r == MODE_DEEP_SLEEP);
    wire in_hib    = (mode_r == MODE_HIBERNATE);
    wire hib_any   = (|hib_src_s) | rtc_wake_s | rst_pin_evt;
    wire hib_wake  = in_hib & hib_any;
    wire deep_rtc  = in_deep & rtc_irq_s & ~rst_pin_evt;
    // volatile state is lost across hibernate; regulator control is kept
    wire soft_clr  = sys_rst_in | hib_wake;
    wire byp_set   = deep_rtc;
    wire byp_clr   = rst_pin_evt;

    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            MODE_FULL_ON, MODE_ACTIVE: begin
                if (rst_pin_evt) begin
                    mode_nxt = MODE_FULL_ON;
                end else if (hib_req) begin
                    mode_nxt = MODE_HIBERNATE;
                end else if (slp_req) begin
                    mode_nxt = MODE_SLEEP;
                end else if (deep_req) begin
                    mode_nxt = MODE_DEEP_SLEEP;
                end else begin
                    mode_nxt = bypass_r ? MODE_ACTIVE : MODE_FULL_ON;
                end
            end
            MODE_SLEEP: begin
                if (rst_pin_evt) begin
                    mode_nxt = MODE_FULL_ON;
                end else if (slp_wake_s | rtc_irq_s) begin
                    mode_nxt = bypass_r ? MODE_ACTIVE : MODE_FULL_ON;
                end
            end
            MODE_DEEP_SLEEP: begin
                // any other event is ignored here
                if (rst_pin_evt) begin
                    mode_nxt = MODE_FULL_ON;
                end else if (rtc_irq_s) begin
                    mode_nxt = MODE_ACTIVE;
                end
            end
            MODE_HIBERNATE: begin
                if (hib_any) begin
                    mode_nxt = MODE_FULL_ON;
                end
            end
            default: begin
                mode_nxt = MODE_FULL_ON;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            mode_r         <= MODE_FULL_ON;
            in_clk_prev_r  <= 1'b0;
            rst_pin_prev_r <= 1'b1;
            hw_reset_out   <= 1'b0;
        end else begin
            mode_r         <= mode_nxt;
            in_clk_prev_r  <= in_clk_s;
            rst_pin_prev_r <= rst_pin_s;
            hw_reset_out   <= rst_pin_evt | (in_hib & rtc_wake_s);
        end
    end

    // volatile control registers
    always_ff @(posedge clk_sys_in) begin
        if (soft_clr) begin
            bypass_r       <= 1'b0;
            pll_off_r      <= 1'b0;
            mult_r         <= `PMC_PLL_MULT_RST;
            ssel_r         <= `PMC_SSEL_RST;
            csel_r         <= `PMC_CSEL_RST;
            sync_clock_output_pin_r  <= 1'b0;
            async_clock_output_pin_r <= 1'b0;
        end else begin
            if (byp_set) begin
                bypass_r <= 1'b1;
            end else if (byp_clr) begin
                bypass_r <= 1'b0;
            end else if (wr_acc & hit_pll & ~(pll_off_r & wd_off & ~wd_byp)) begin
                // leaving bypass is refused while the PLL is off unless the same write enables it
                bypass_r <= wd_byp | (pll_off_r & wd_off);
            end
            if (wr_acc & hit_pll) begin
                pll_off_r <= wd_off & (bypass_r | wd_byp);
                if (wd_mult != 6'h00) begin
                    mult_r <= wd_mult;
                end
            end
            if (wr_acc & hit_div) begin
                // takes effect without relock; dividers pick it up at wrap
                if (wd_ssel >= `PMC_SSEL_MIN) begin
                    ssel_r <= wd_ssel;
                end
                csel_r <= avs_writedata_in[`PMC_CSEL_MSB:`PMC_CSEL_LSB];
            end
            if (wr_acc & hit_smem) begin
                sync_clock_output_pin_r <= avs_writedata_in[`PMC_CLOCK_OUTPUT_PIN_EN_BIT];
            end
            if (wr_acc & hit_amem) begin
                async_clock_output_pin_r <= avs_writedata_in[`PMC_CLOCK_OUTPUT_PIN_EN_BIT];
            end
        end
    end

    // retained regulator control; frequency restored on wake so hibernate is not re-entered
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            regulator_frequency_field_r     <= `PMC_REGULATOR_FREQUENCY_FIELD_RST;
            vr_spare_r <= `PMC_VR_SPARE_RST;
        end else if (hib_wake) begin
            regulator_frequency_field_r     <= `PMC_REGULATOR_FREQUENCY_FIELD_RST;
        end else if (wr_acc & hit_vr) begin
            regulator_frequency_field_r     <= wd_regulator_frequency_field;
            vr_spare_r <= avs_writedata_in[`PMC_VR_SPARE_MSB:`PMC_VR_SPARE_LSB];
        end
    end

    // avalon slave: one wait cycle, then answer
    wire [31:0] rd_mux = hit_pll ? {24'h0, pll_off_r, mult_r, bypass_r} :
        hit_div  ? {26'h0, csel_r, ssel_r} :
        hit_vr   ? {24'h0, vr_spare_r, regulator_frequency_field_r} :
        hit_mode ? {29'h0, mode_r} :
        hit_smem ? {31'h0, sync_clock_output_pin_r} :
        hit_amem ? {31'h0, async_clock_output_pin_r} : 32'h0000_0000;
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            wait_r           <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            wait_r           <= ~((avs_read_in | avs_write_in) & wait_r);
            avs_readdata_out <= (avs_read_in & wait_r) ? rd_mux : avs_readdata_out;
        end
    end
    assign avs_waitrequest_out = wait_r;

    // clock generation; PLL output modelled as one tick per system edge
    wire       core_run = running;
    wire       sys_run  = running | (mode_r == MODE_SLEEP);
    wire       src_tick = bypass_r ? in_tick : 1'b1;
    wire [3:0] core_div = bypass_r ? 4'h1 : (4'h1 << csel_r);
    wire [3:0] sys_div  = bypass_r ? 4'h1 : ssel_r;
    wire       clock_output_pin_en = sync_clock_output_pin_r | async_clock_output_pin_r;
    logic      core_en_d;
    logic      sys_en_d;
    logic      sys_lvl_d;

    clk_div u_core_div (
        .clk_in    (clk_sys_in),
        .rst_in    (soft_clr),
        .tick_in   (src_tick),
        .ratio_in  (core_div),
        .en_out    (core_en_d),
        .level_out ()
    );

    clk_div u_sys_div (
        .clk_in    (clk_sys_in),
        .rst_in    (soft_clr),
        .tick_in   (src_tick),
        .ratio_in  (sys_div),
        .en_out    (sys_en_d),
        .level_out (sys_lvl_d)
    );

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            core_clk_en_out      <= 1'b0;
            sys_clk_en_out       <= 1'b0;
            clock_output_pin_out <= 1'b0;
            clock_output_oe_out  <= 1'b0;
            pins_hiz_out         <= 1'b0;
            vddint_on_out        <= 1'b1;
            async_block_out      <= 1'b0;
            pll_mult_out         <= `PMC_PLL_MULT_RST;
        end else begin
            core_clk_en_out      <= core_en_d & core_run;
            sys_clk_en_out       <= sys_en_d & sys_run;
            // bypass runs at the input rate, so the pin follows the synced input clock
            clock_output_pin_out <= (bypass_r ? in_clk_s : sys_lvl_d) & sys_run & clock_output_pin_en;
            clock_output_oe_out  <= clock_output_pin_en & ~in_hib;
            pins_hiz_out         <= in_hib;
            vddint_on_out        <= ~in_hib;
            async_block_out      <= in_deep | in_hib;
            pll_mult_out         <= mult_r;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_hib_entered;
        mode_r == MODE_HIBERNATE;
    endsequence
    sequence s_power_down;
        !vddint_on_out && !core_clk_en_out && !sys_clk_en_out;
    endsequence
    a_deep_gates_clocks: assert property (in_deep |=> !core_clk_en_out && !sys_clk_en_out)
        else $error("clock enable seen in deep sleep");
    a_deep_blocks_access: assert property (in_deep |=> async_block_out)
        else $error("async access not blocked in deep sleep");
    a_deep_ignores_wake: assert property (
        in_deep && !rtc_irq_s && !rst_pin_evt |=> mode_r == MODE_DEEP_SLEEP)
        else $error("deep sleep left without reset or rtc");
    a_rtc_to_active: assert property (
        deep_rtc |=> mode_r == MODE_ACTIVE && bypass_r ##1 mode_r == MODE_ACTIVE)
        else $error("rtc wake did not give bypassed active mode");
    a_reset_to_full: assert property (in_deep && rst_pin_evt |=> mode_r == MODE_FULL_ON && !bypass_r)
        else $error("reset in deep sleep did not give full-on");
    a_regulator_frequency_field_zero_hib: assert property (hib_req && !rst_pin_evt |=> s_hib_entered ##1 s_power_down)
        else $error("frequency 00 did not power down");
    a_hib_tristate: assert property (in_hib |=> pins_hiz_out && !clock_output_oe_out)
        else $error("pins driven in hibernate");
    a_hib_wake: assert property (hib_wake |=> mode_r == MODE_FULL_ON ##1 vddint_on_out)
        else $error("wake source did not end hibernate");
    a_hib_reset_seq: assert property (in_hib && (rtc_wake_s || rst_pin_evt) |=> hw_reset_out)
        else $error("reset sequence not started on wake");
    a_retain_reg: assert property (
        hib_wake |=> vr_spare_r == $past(vr_spare_r) && ssel_r == `PMC_SSEL_RST && !bypass_r)
        else $error("retention across hibernate wrong");
    a_clock_output_pin_gated: assert property (!clock_output_pin_en |=> !clock_output_pin_out)
        else $error("clock pin active while disabled");
    a_ssel_range: assert property (ssel_r >= `PMC_SSEL_MIN)
        else $error("system divider outside 2..15");
endmodule
`default_nettype wire

// ==== tb/power_mode_clock_control_tb_top.sv ====
// self-checking bench for the power-mode and clock controller
`timescale 1ns/100ps
`default_nettype none
`include "pmc_defines.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module power_mode_clock_control_tb_top
    import pmc_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst;
    logic [4:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        wreq;
    logic        ic = 1'b0;
    logic [3:0]  ic_cnt = 4'h0;
    logic        rpin_n;
    logic        rtc_irq;
    logic        rtc_wk;
    logic        slp_wk;
    logic [4:0]  hwk;
    logic        cen, sen, cpin, coe, hiz, vdd, blk, hwr;
    logic [5:0]  mult;
    int          num_errors = 0;
    int          tests_run = 0;

    power_mode_clock_control dut (.clk_sys_in(clk), .sys_rst_in(rst), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .input_clock_in(ic), .reset_pin_n_in(rpin_n),
        .rtc_irq_in(rtc_irq), .rtc_wakeup_in(rtc_wk), .sleep_wake_in(slp_wk), .hib_wake_in(hwk),
        .core_clk_en_out(cen), .sys_clk_en_out(sen), .clock_output_pin_out(cpin),
        .clock_output_oe_out(coe), .pins_hiz_out(hiz), .vddint_on_out(vdd),
        .async_block_out(blk), .hw_reset_out(hwr), .pll_mult_out(mult));

    always #2.5 clk = ~clk;

    // input clock at one sixteenth of the system clock
    always @(posedge clk) begin
        ic_cnt <= ic_cnt + 4'h1;
        ic     <= ic_cnt[3];
    end

    task automatic report_and_stop();
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // values read right after an edge are the ones sampled at that edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        rd    <= !w;
        wr    <= w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (n >= 50)
            num_errors++;
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        `CHK(q, e)
    endtask

    function automatic int sel(input int k);
        case (k)
            0: return int'(cen === 1'b1);
            1: return int'(sen === 1'b1);
            2: return int'(hwr === 1'b1);
            default: return int'(cpin === 1'b1);
        endcase
    endfunction

    task automatic cnt(input int k, input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            c += sel(k);
        end
    endtask

    task automatic per(input int k, output int p);
        int n;
        n = 0;
        do begin @(posedge clk); n++; end while (sel(k) == 0 && n < 200);
        p = 0;
        do begin @(posedge clk); p++; end while (sel(k) == 0 && p < 200);
    endtask

    task automatic t_reset();
        `CHK(mult, 6'h0A)
        `CHK({vdd, coe, cpin, hiz, blk}, 5'h10)
        rd_chk(`PMC_OFF_PLL_CONTROL_REGISTER, 32'h0000_0014);
        rd_chk(`PMC_OFF_DIVIDER, 32'h0000_0005);
        rd_chk(`PMC_OFF_REGULATOR, 32'h0000_0003);
        rd_chk(`PMC_OFF_MODE, 32'h0000_0000);
        wr_reg(5'h18, 32'hFFFF_FFFF);
        rd_chk(5'h18, 32'h0000_0000);
    endtask

    task automatic t_div();
        int p;
        per(1, p);
        `CHK(p, 5)
        per(0, p);
        `CHK(p, 1)
        for (int c = 0; c < 4; c++) begin
            wr_reg(`PMC_OFF_DIVIDER, 32'h0000_0002 | (c << 4));
            per(0, p);
            per(0, p);
            `CHK(p, 1 << c)
        end
        per(1, p);
        `CHK(p, 2)
        wr_reg(`PMC_OFF_DIVIDER, 32'h0000_0031);
        rd_chk(`PMC_OFF_DIVIDER, 32'h0000_0032);
        wr_reg(`PMC_OFF_DIVIDER, 32'h0000_000F);
        per(1, p);
        per(1, p);
        `CHK(p, 15)
        wr_reg(`PMC_OFF_DIVIDER, 32'h0000_0005);
    endtask

    task automatic t_mult();
        wr_reg(`PMC_OFF_PLL_CONTROL_REGISTER, 32'h0000_007E);
        cyc(2);
        `CHK(mult, 6'h3F)
        wr_reg(`PMC_OFF_PLL_CONTROL_REGISTER, 32'h0000_0002);
        wr_reg(`PMC_OFF_PLL_CONTROL_REGISTER, 32'h0000_0000);
        cyc(2);
        `CHK(mult, 6'h01)
        wr_reg(`PMC_OFF_PLL_CONTROL_REGISTER, 32'h0000_0014);
    endtask

    task automatic t_pin();
        int c;
        for (int i = 0; i < 2; i++) begin
            wr_reg(i ? `PMC_OFF_ASYNC_MEM : `PMC_OFF_SYNC_MEM, 32'h0000_0001);
            cyc(3);
            cnt(3, 40, c);
            `CHK({coe, c > 0, c < 40}, 3'h7)
            wr_reg(i ? `PMC_OFF_ASYNC_MEM : `PMC_OFF_SYNC_MEM, 32'h0000_0000);
            cyc(3);
            `CHK({coe, cpin}, 2'h0)
        end
    endtask

    task automatic t_sleep();
        int c;
        int p;
        wr_reg(`PMC_OFF_MODE, 32'h0000_0001);
        cyc(3);
        rd_chk(`PMC_OFF_MODE, MODE_SLEEP);
        cnt(0, 20, c);
        `CHK(c, 0)
        slp_wk <= 1'b1;
        cyc(10);
        slp_wk <= 1'b0;
        rd_chk(`PMC_OFF_MODE, MODE_FULL_ON);
        wr_reg(`PMC_OFF_MODE, 32'h0000_0002);
        cyc(3);
        rd_chk(`PMC_OFF_MODE, MODE_DEEP_SLEEP);
        `CHK(blk, 1'b1)
        cnt(0, 40, c);
        cnt(1, 40, p);
        `CHK(c + p, 0)
        slp_wk <= 1'b1;
        hwk    <= 5'h1F;
        cyc(12);
        slp_wk <= 1'b0;
        hwk    <= 5'h00;
        rd_chk(`PMC_OFF_MODE, MODE_DEEP_SLEEP);
        rtc_irq <= 1'b1;
        cyc(12);
        rtc_irq <= 1'b0;
        rd_chk(`PMC_OFF_MODE, MODE_ACTIVE);
        rd_chk(`PMC_OFF_PLL_CONTROL_REGISTER, 32'h0000_0015);
        `CHK(blk, 1'b0)
        per(1, p);
        per(1, p);
        `CHK(p, 16)
        per(0, p);
        `CHK(p, 16)
        wr_reg(`PMC_OFF_SYNC_MEM, 32'h0000_0001);
        cyc(2);
        cnt(3, 16, c);
        `CHK(c, 8)
        wr_reg(`PMC_OFF_SYNC_MEM, 32'h0000_0000);
        wr_reg(`PMC_OFF_PLL_CONTROL_REGISTER, 32'h0000_0095);
        rd_chk(`PMC_OFF_PLL_CONTROL_REGISTER, 32'h0000_0095);
        wr_reg(`PMC_OFF_PLL_CONTROL_REGISTER, 32'h0000_0094);
        rd_chk(`PMC_OFF_PLL_CONTROL_REGISTER, 32'h0000_0095);
        wr_reg(`PMC_OFF_MODE, 32'h0000_0001);
        cyc(3);
        rd_chk(`PMC_OFF_MODE, MODE_ACTIVE);
        wr_reg(`PMC_OFF_PLL_CONTROL_REGISTER, 32'h0000_0015);
        wr_reg(`PMC_OFF_MODE, 32'h0000_0002);
        cyc(3);
        rpin_n <= 1'b0;
        cnt(2, 15, c);
        `CHK(c, 1)
        rpin_n <= 1'b1;
        cyc(8);
        rd_chk(`PMC_OFF_MODE, MODE_FULL_ON);
    endtask

    task automatic t_hib();
        int c;
        for (int i = 0; i < 7; i++) begin
            wr_reg(`PMC_OFF_DIVIDER, 32'h0000_0012);
            wr_reg(`PMC_OFF_REGULATOR, 32'h0000_00F0);
            cyc(3);
            cnt(1, 20, c);
            `CHK({hiz, vdd, blk, c == 0}, 4'hB)
            if (i < 5)
                hwk[i] <= 1'b1;
            else if (i == 5)
                rtc_wk <= 1'b1;
            else
                rpin_n <= 1'b0;
            cnt(2, 15, c);
            `CHK(c, int'(i >= 5))
            hwk    <= 5'h00;
            rtc_wk <= 1'b0;
            rpin_n <= 1'b1;
            cyc(8);
            `CHK({hiz, vdd}, 2'h1)
            rd_chk(`PMC_OFF_REGULATOR, 32'h0000_00F3);
            rd_chk(`PMC_OFF_DIVIDER, 32'h0000_0005);
        end
    endtask

    initial begin
        rst = 1'b1; addr = 5'h00; rd = 1'b0; wr = 1'b0; wdata = 32'h0000_0000;
        rpin_n = 1'b1; rtc_irq = 1'b0; rtc_wk = 1'b0; slp_wk = 1'b0; hwk = 5'h00;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        cyc(2);
        t_reset();
        t_div();
        t_mult();
        t_pin();
        t_sleep();
        t_hib();
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
